// >>> msq_consts.svh
`ifndef MSQ_CONSTS_SVH
`define MSQ_CONSTS_SVH
// ----------------------------------------
// Sequence timing in conversion clocks, result counter steps and limit, clock rate in Hz
// ----------------------------------------
`define MSQ_CYCLE_COUNTS      2048
`define MSQ_INT_COUNTS_60HZ   545
`define MSQ_INT_COUNTS_50HZ   655
`define MSQ_PRE_ZI_60HZ       111
`define MSQ_PRE_ZI_50HZ       1
`define MSQ_POST_ZI_COUNTS    20
`define MSQ_DEINT_MAX_COUNTS  128
`define MSQ_X8_COUNTS         16
`define MSQ_POL_EARLY_COUNTS  2
`define MSQ_STEP_DEINT1       512
`define MSQ_STEP_DEINT2       64
`define MSQ_STEP_DEINT3       8
`define MSQ_STEP_DEINT4       1
`define MSQ_HARD_LIMIT        350440
`define MSQ_CONV_CLK_HZ       32768
`endif

// >>> msq_pkg.sv
package msq_pkg;
  typedef enum logic [6:0] {
    MSQ_ZERO_INT = 7'h01,
    MSQ_PRE_ZI   = 7'h02,
    MSQ_INTEG    = 7'h04,
    MSQ_DEINT    = 7'h08,
    MSQ_REST     = 7'h10,
    MSQ_TIMES8   = 7'h20,
    MSQ_POST_ZI  = 7'h40
  } msq_phase_t;
endpackage

// >>> msq_sequencer.sv
`timescale 1ns/100ps
`include "msq_consts.svh"
// Notes on behaviour
// - Result range up to 350,440 counts from a 32.768 kHz conversion clock.
// - Deintegration ends on the clock edge after the comparator zero crossing.
// - Integrate routes low terminal to integrator, high terminal to buffer.
// - Integrate lasts 545 clocks in 60 Hz mode, 655 in 50 Hz mode.
// - Integrator polarity at integrate end picks first deintegration direction.
// - First deintegration ends at discharge, then rest with inputs at ground.
// - Polarity resampled shortly before maximum deintegration period expires, only if rest has already begun by then.
// - Every deintegration followed by rest until that phase's maximum count.
// - After first deintegration a times-eight phase inverts and multiplies residue.
// - Second and third deintegrations also followed by times-eight; three times-eight phases, four deintegrations in all.
// - Residue deintegrations count opposite to the preceding one after an overshoot, same way otherwise.
// - Hold in zero-integrate from reset until a start arrives.
// - After start, 111 more zero-integrate clocks at 60 Hz, one at 50 Hz.
// - Twenty zero-integrate clocks at the end of every conversion.
// - Results counter steps 512, 64, 8 then 1 across the four deintegrations.
// - Done flag set as post zero-integrate ends, cleared by the next start.
// - Results counter copied into results register as the last rest ends, before post zero-integrate.
// - Results beyond hard limit saturate at plus or minus 350,440.
module msq_sequencer
  import msq_pkg::*;
#(
  parameter int RES_W = 20
) (
  input  wire logic             ref_clk_in,
  input  wire logic             arst_n_in,
  input  wire logic             clk_en_in,
  input  wire logic             start_in,
  input  wire logic             mode_50hz_in,
  input  wire logic             comp_zero_in,
  input  wire logic             int_positive_in,
  output logic                  sw_input_low_terminal_out,
  output logic                  sw_input_high_terminal_out,
  output logic                  sw_agnd_out,
  output logic                  sw_deint_pos_out,
  output logic                  sw_deint_neg_out,
  output logic                  sw_times_eight_phase_out,
  output logic                  sw_zero_int_out,
  output logic                  integrating_out,
  output logic                  conv_done_out,
  output logic signed [RES_W-1:0] result_out
);
  // ----------------------------------------
  // Constants
  // ----------------------------------------
  localparam logic [9:0]  INT_60     = 10'(`MSQ_INT_COUNTS_60HZ);
  localparam logic [9:0]  INT_50     = 10'(`MSQ_INT_COUNTS_50HZ);
  localparam logic [9:0]  PRE_60     = 10'(`MSQ_PRE_ZI_60HZ);
  localparam logic [9:0]  PRE_50     = 10'(`MSQ_PRE_ZI_50HZ);
  localparam logic [9:0]  POST_ZI    = 10'(`MSQ_POST_ZI_COUNTS);
  localparam logic [9:0]  DEINT_MAX  = 10'(`MSQ_DEINT_MAX_COUNTS);
  localparam logic [9:0]  X8_LEN     = 10'(`MSQ_X8_COUNTS);
  localparam logic [9:0]  POL_EARLY  = 10'(`MSQ_POL_EARLY_COUNTS);
  localparam logic signed [RES_W-1:0] LIM_POS = RES_W'(`MSQ_HARD_LIMIT);
  localparam logic signed [RES_W-1:0] LIM_NEG = -RES_W'(`MSQ_HARD_LIMIT);

  // ----------------------------------------
  // State
  // ----------------------------------------
  msq_phase_t                phase;
  logic [9:0]                phase_cnt;
  logic [1:0]                deint_idx;
  logic                      dir_pos;
  logic                      cnt_up;
  logic                      zc_seen;
  logic signed [RES_W-1:0]   res_cnt;
  logic signed [RES_W-1:0]   step;
  logic signed [RES_W-1:0]   next_res;
  logic signed [RES_W+1:0]   sum_wide;
  logic                      last_deint;
  logic                      phase_end;

  always_comb begin
    unique case (deint_idx)
      2'd0: step = RES_W'(`MSQ_STEP_DEINT1);
      2'd1: step = RES_W'(`MSQ_STEP_DEINT2);
      2'd2: step = RES_W'(`MSQ_STEP_DEINT3);
      2'd3: step = RES_W'(`MSQ_STEP_DEINT4);
    endcase
  end

  // Saturating accumulate; wide sum avoids wrap before the limit check
  always_comb begin
    if (cnt_up) begin
      sum_wide = (RES_W+2)'(res_cnt) + (RES_W+2)'(step);
    end else begin
      sum_wide = (RES_W+2)'(res_cnt) - (RES_W+2)'(step);
    end
    if (sum_wide > (RES_W+2)'(LIM_POS)) begin
      next_res = LIM_POS;
    end else if (sum_wide < (RES_W+2)'(LIM_NEG)) begin
      next_res = LIM_NEG;
    end else begin
      next_res = RES_W'(sum_wide);
    end
  end

  assign last_deint = (deint_idx == 2'd3);
  assign phase_end  = (phase_cnt == 10'd1);

  // ----------------------------------------
  // Phase sequencing
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      phase     <= MSQ_ZERO_INT;
      phase_cnt <= 10'h000;
      deint_idx <= 2'h0;
      zc_seen   <= 1'b0;
    end else if (clk_en_in) begin
      unique case (phase)
        MSQ_ZERO_INT: begin
          if (start_in) begin
            phase     <= MSQ_PRE_ZI;
            phase_cnt <= mode_50hz_in ? PRE_50 : PRE_60;
          end
        end
        MSQ_PRE_ZI: begin
          if (phase_end) begin
            phase     <= MSQ_INTEG;
            phase_cnt <= mode_50hz_in ? INT_50 : INT_60;
          end else begin
            phase_cnt <= phase_cnt - 10'd1;
          end
        end
        MSQ_INTEG: begin
          if (phase_end) begin
            phase     <= MSQ_DEINT;
            phase_cnt <= DEINT_MAX;
            deint_idx <= 2'h0;
            zc_seen   <= 1'b0;
          end else begin
            phase_cnt <= phase_cnt - 10'd1;
          end
        end
        MSQ_DEINT: begin
          // Comparator sampled at this edge; switch outputs follow on the next edge, not async
          if (comp_zero_in || phase_end) begin
            phase   <= MSQ_REST;
            zc_seen <= 1'b1;
          end
          // Held at one so a full-length deintegration still gets a rest edge
          if (!phase_end) begin
            phase_cnt <= phase_cnt - 10'd1;
          end
        end
        MSQ_REST: begin
          if (phase_end) begin
            if (last_deint) begin
              phase     <= MSQ_POST_ZI;
              phase_cnt <= POST_ZI;
            end else begin
              phase     <= MSQ_TIMES8;
              phase_cnt <= X8_LEN;
            end
          end else begin
            phase_cnt <= phase_cnt - 10'd1;
          end
        end
        MSQ_TIMES8: begin
          if (phase_end) begin
            phase     <= MSQ_DEINT;
            phase_cnt <= DEINT_MAX;
            deint_idx <= deint_idx + 2'd1;
            zc_seen   <= 1'b0;
          end else begin
            phase_cnt <= phase_cnt - 10'd1;
          end
        end
        MSQ_POST_ZI: begin
          if (phase_end) begin
            phase <= MSQ_ZERO_INT;
          end else begin
            phase_cnt <= phase_cnt - 10'd1;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Deintegration polarity
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dir_pos <= 1'b0;
      cnt_up  <= 1'b0;
    end else if (clk_en_in) begin
      if (phase == MSQ_INTEG && phase_end) begin
        dir_pos <= int_positive_in;
        cnt_up  <= int_positive_in;
      end else if (phase == MSQ_REST && phase_cnt == POL_EARLY) begin
        // Sampled before times-eight, which flips the residue's sign
        dir_pos <= !int_positive_in;
        // Overshoot past zero reverses the count; undershoot keeps it
        cnt_up  <= cnt_up ^ (int_positive_in != dir_pos);
      end
    end
  end

  // ----------------------------------------
  // Results counter and register
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      res_cnt <= '0;
    end else if (clk_en_in) begin
      if (phase == MSQ_INTEG) begin
        res_cnt <= '0;
      end else if (phase == MSQ_DEINT) begin
        res_cnt <= next_res;
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      result_out <= '0;
    end else if (clk_en_in) begin
      if (phase == MSQ_REST && phase_end && last_deint) begin
        result_out <= res_cnt;
      end
    end
  end

  // ----------------------------------------
  // Done flag
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      conv_done_out <= 1'b0;
    end else if (clk_en_in) begin
      if (phase == MSQ_POST_ZI && phase_end) begin
        conv_done_out <= 1'b1;
      end else if (phase == MSQ_ZERO_INT && start_in) begin
        conv_done_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Switch commands, registered for glitch-free analog drive
  // ----------------------------------------
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sw_input_low_terminal_out  <= 1'b0;
      sw_input_high_terminal_out <= 1'b0;
      sw_agnd_out                <= 1'b0;
      sw_deint_pos_out           <= 1'b0;
      sw_deint_neg_out           <= 1'b0;
      sw_times_eight_phase_out   <= 1'b0;
      sw_zero_int_out            <= 1'b1;
      integrating_out            <= 1'b0;
    end else if (clk_en_in) begin
      sw_input_low_terminal_out  <= (phase == MSQ_INTEG);
      sw_input_high_terminal_out <= (phase == MSQ_INTEG);
      sw_agnd_out                <= (phase == MSQ_REST);
      sw_deint_pos_out           <= (phase == MSQ_DEINT) && dir_pos;
      sw_deint_neg_out           <= (phase == MSQ_DEINT) && !dir_pos;
      sw_times_eight_phase_out   <= (phase == MSQ_TIMES8);
      sw_zero_int_out            <= (phase == MSQ_ZERO_INT) || (phase == MSQ_PRE_ZI)
                                    || (phase == MSQ_POST_ZI);
      integrating_out            <= (phase == MSQ_INTEG);
    end
  end
endmodule

// >>> msq_sequencer_asserts.sv
`timescale 1ns/100ps
`include "msq_consts.svh"
module msq_sequencer_asserts #(
  parameter int RES_W = 20
) (
  input wire logic              ref_clk_in,
  input wire logic              arst_n_in,
  input wire logic              clk_en_in,
  input wire logic              start_in,
  input wire logic              mode_50hz_in,
  input wire logic              comp_zero_in,
  input wire logic              int_positive_in,
  input wire logic              sw_input_low_terminal_out,
  input wire logic              sw_input_high_terminal_out,
  input wire logic              sw_agnd_out,
  input wire logic              sw_deint_pos_out,
  input wire logic              sw_deint_neg_out,
  input wire logic              sw_times_eight_phase_out,
  input wire logic              sw_zero_int_out,
  input wire logic              integrating_out,
  input wire logic              conv_done_out,
  input wire logic signed [RES_W-1:0] result_out
);
  // ----------------------------------------
  // Phase length counters, enabled edges only
  // ----------------------------------------
  int icnt;
  int xcnt;
  wire logic deint = sw_deint_pos_out || sw_deint_neg_out;
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) icnt <= 0;
    else if (clk_en_in) icnt <= integrating_out ? icnt + 1 : 0;
  end
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) xcnt <= 0;
    else if (clk_en_in) xcnt <= sw_times_eight_phase_out ? xcnt + 1 : 0;
  end
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  AST_INT_ROUTE: assert property (
    integrating_out == (sw_input_low_terminal_out && sw_input_high_terminal_out))
    else $error("integrate routing wrong");
  AST_INT_LEN: assert property (
    $fell(integrating_out) |-> icnt == (mode_50hz_in ? `MSQ_INT_COUNTS_50HZ : `MSQ_INT_COUNTS_60HZ))
    else $error("integrate length wrong");
  AST_DEINT_DIR: assert property (
    $fell(integrating_out) |-> sw_deint_pos_out == $past(int_positive_in) && deint)
    else $error("first deintegration direction wrong");
  AST_DEINT_STOP: assert property (
    deint && comp_zero_in && clk_en_in |-> ##[1:2] sw_agnd_out)
    else $error("deintegration did not stop");
  AST_REST_GND: assert property (
    sw_agnd_out |-> !deint && !sw_input_low_terminal_out && !sw_times_eight_phase_out)
    else $error("rest routing wrong");
  AST_REST_NEXT: assert property (
    $fell(sw_agnd_out) |-> sw_times_eight_phase_out || sw_zero_int_out)
    else $error("rest not followed by times eight");
  AST_X8_LEN: assert property (
    $fell(sw_times_eight_phase_out) |-> xcnt == `MSQ_X8_COUNTS && deint)
    else $error("times eight phase wrong");
  AST_DONE_CLR: assert property (
    conv_done_out && start_in && clk_en_in && sw_zero_int_out |=> !conv_done_out)
    else $error("done not cleared on start");
  AST_POST_ZI: assert property (
    $rose(conv_done_out) |-> $past(sw_zero_int_out, 19) && sw_zero_int_out)
    else $error("post zero integrate too short");
  AST_RES_HOLD: assert property (
    integrating_out |-> $stable(result_out))
    else $error("result moved mid conversion");
  AST_SAT: assert property (
    result_out <= `MSQ_HARD_LIMIT && result_out >= -`MSQ_HARD_LIMIT)
    else $error("result beyond hard limit");
endmodule
bind msq_sequencer msq_sequencer_asserts #(.RES_W(RES_W)) u_chk (.*);

// >>> msq_analog_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Integrator, x8 stage and comparator
// ----------------------------------------
module msq_analog_model (
  input  wire logic clk_in,
  input  wire logic en_in,
  input  wire logic low_in,
  input  wire logic pos_in,
  input  wire logic neg_in,
  input  wire logic x8_in,
  input  wire logic zi_in,
  input  real       vin_in,
  output logic      zero_out,
  output logic      pol_out
);
  real  v = 0.0;
  logic x8_q = 1'b0;
  initial begin
    zero_out = 1'b0;
    pol_out = 1'b0;
  end
  // Frozen with the sequencer so edge counts stay aligned
  always @(posedge clk_in) begin
    if (en_in) begin
      x8_q <= x8_in;
      if (zi_in) v = 0.0;
      else if (low_in) v = v + vin_in;
      else if (x8_in && !x8_q) v = -8.0 * v;
      else if (pos_in) v = v - 1.0;
      else if (neg_in) v = v + 1.0;
      zero_out <= pos_in ? v <= 0.0 : neg_in && v >= 0.0;
      pol_out <= v > 0.0;
    end
  end
endmodule

// >>> multislope_adc_phase_sequencer_test.sv
`timescale 1ns/100ps
module multislope_adc_phase_sequencer_test;
  logic ref_clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic clk_en_in = 1'b1;
  logic start_in = 1'b0;
  logic mode_50hz_in = 1'b0;
  logic comp_zero_in;
  logic int_positive_in;
  logic sw_input_low_terminal_out;
  logic sw_input_high_terminal_out;
  logic sw_agnd_out;
  logic sw_deint_pos_out;
  logic sw_deint_neg_out;
  logic sw_times_eight_phase_out;
  logic sw_zero_int_out;
  logic integrating_out;
  logic conv_done_out;
  logic signed [19:0] result_out;
  real  vin = 0.0;
  int   err_total = 0;
  int   samples_checked = 0;
  always #20 ref_clk_in = ~ref_clk_in;
  msq_sequencer #(.RES_W(20)) dut (.*);
  msq_analog_model u_model (.clk_in(ref_clk_in), .en_in(clk_en_in),
    .low_in(sw_input_low_terminal_out), .pos_in(sw_deint_pos_out),
    .neg_in(sw_deint_neg_out), .x8_in(sw_times_eight_phase_out),
    .zi_in(sw_zero_int_out), .vin_in(vin), .zero_out(comp_zero_in),
    .pol_out(int_positive_in));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("Error at %0t: got %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic complete_run();
    $display("Checks %0d, errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic idle_check();
    check({sw_zero_int_out, conv_done_out, result_out}, 22'h200000);
    repeat (30) @(posedge ref_clk_in);
    #1;
    check({sw_zero_int_out, integrating_out, sw_agnd_out}, 3'h4);
  endtask
  // ----------------------------------------
  // One conversion; 60 Hz run pauses the enable
  // ----------------------------------------
  task automatic run_conv(input logic m, input real v, output int pre);
    int   nd = 0;
    int   nx = 0;
    int   il = 0;
    int   k;
    int   dif;
    logic seen_i = 1'b0;
    logic d_q = 1'b0;
    logic x_q = 1'b0;
    logic en;
    vin = v;
    pre = 0;
    @(posedge ref_clk_in);
    mode_50hz_in <= m;
    start_in <= 1'b1;
    @(posedge ref_clk_in);
    start_in <= 1'b0;
    #1;
    for (k = 0; k < 3000 && conv_done_out !== 1'b1; k++) begin
      @(posedge ref_clk_in);
      en = clk_en_in;
      clk_en_in <= !(!m && integrating_out && k % 50 == 0);
      // Start mid-conversion must be ignored
      start_in <= (k == 700);
      #1;
      seen_i = seen_i || integrating_out;
      if (!seen_i) pre++;
      if (integrating_out && en) il++;
      if ((sw_deint_pos_out || sw_deint_neg_out) && !d_q) nd++;
      if (sw_times_eight_phase_out && !x_q) nx++;
      d_q = sw_deint_pos_out || sw_deint_neg_out;
      x_q = sw_times_eight_phase_out;
    end
    check(conv_done_out, 1'b1);
    check(nd, 4);
    check(nx, 3);
    check(il, m ? 655 : 545);
    dif = int'(result_out) - $rtoi(512.0 * v * il);
    check(dif <= 24 && dif >= -24, 1'b1);
  endtask
  initial begin
    #800000;
    err_total++;
    complete_run();
  end
  initial begin
    int p60;
    int p50;
    repeat (20) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    idle_check();
    // Back to back, no idle gap; each run pulses start mid-conversion
    run_conv(1'b0, 0.1, p60);
    run_conv(1'b1, -0.15, p50);
    check(p60 - p50, 110);
    complete_run();
  end
endmodule
